// ===== core/spi_flag_consts.svh
`ifndef SPI_FLAG_CONSTS_SVH
`define SPI_FLAG_CONSTS_SVH
// How it works
// R1: A data write while busy sets write collision, bit 6.
// R2: Write collision clears on a 0 written to it or a data write while not busy.
// R3: Enabled controller mode with select-input-disable clear and select pin low sets mode fault, bit 5.
// R4: Mode fault stays set until software writes 0 to it.
// R5: Mode fault clears the port enable and controller select control bits.
// R6: Transfer end with receive full already set sets receive overrun, bit 4.
// R7: Receive overrun clears on a 0 written to it or a data register read.
// R8: Every transfer end sets receive full, bit 3; a 0 write or data read clears it.
// R9: Busy, bit 2, is read-only and high while a transfer is in progress.
// R10: One data register: writes give the byte to send, reads return the byte received.
// R11: All status bits read 0 after reset.
// R12: Transfer complete, bit 7, clears on interrupt acknowledge or a 0 written to it.
// R13: A data write while idle and enabled as controller starts a transfer and sets busy.

`define PCLK_PERIOD_NS 100
`define LINK_PERIOD_NS 800
`define SCK_HALF_CYC ((`LINK_PERIOD_NS / 2) / `PCLK_PERIOD_NS)

`define IDX_STATUS 10'h0bd
`define IDX_DATA 10'h0be
`define IDX_CTRL 10'h0bf
`define IDX_MASK 10'h0c0

`define BIT_CPL 7
`define BIT_COLL 6
`define BIT_FAULT 5
`define BIT_OVF 4
`define BIT_FULL 3
`define BIT_BUSY 2

`define CTL_EN 0
`define CTL_CTRLR 1
`define CTL_SELDIS 2
`define CTL_WMASK 8'h07

`define STATUS_RST 8'h00
`define CTRL_RST 8'h00
`define MASK_RST 8'h00
`define DATA_RST 8'h00
`endif

// ===== core/spi_flag_pkg.sv
package spi_flag_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SHIFT = 2'h1,
    ST_END = 2'h3
  } shift_state_t;
endpackage

// ===== core/spi_shifter.sv
`timescale 1ns/10ps
`include "spi_flag_consts.svh"
module spi_shifter #(
  parameter int HALF_CYC = `SCK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic controller,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  input wire logic sck_s,
  input wire logic sel_n_s,
  input wire logic sdi_s,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte,
  output logic sck_out,
  output logic sdo
);
  spi_flag_pkg::shift_state_t state_q;
  spi_flag_pkg::shift_state_t state_d;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic [2:0] cnt_q;
  logic [15:0] div_q;
  logic sck_gen_q;
  logic sck_prev_q;

  wire tick = (div_q == 16'(HALF_CYC - 1));
  wire gen_on = (state_q == spi_flag_pkg::ST_SHIFT) && controller;
  wire rise = controller ? (tick && !sck_gen_q) : (sck_s && !sck_prev_q);
  wire fall = controller ? (tick && sck_gen_q) : (!sck_s && sck_prev_q);
  wire last = fall && (cnt_q == 3'h7);
  wire p_go = !controller && !sel_n_s;
  // Peripheral transfer dies when the select is dropped mid-byte
  wire abort = !enable || (!controller && sel_n_s);
  wire load = (state_q == spi_flag_pkg::ST_IDLE) && (state_d == spi_flag_pkg::ST_SHIFT);

  always_comb begin
    state_d = state_q;
    case (state_q)
      spi_flag_pkg::ST_IDLE: begin
        if (enable && ((controller && start) || p_go)) begin
          state_d = spi_flag_pkg::ST_SHIFT; // [R13]
        end
      end
      spi_flag_pkg::ST_SHIFT: begin
        if (abort) begin
          state_d = spi_flag_pkg::ST_IDLE;
        end else if (last) begin
          state_d = spi_flag_pkg::ST_END;
        end
      end
      spi_flag_pkg::ST_END: state_d = spi_flag_pkg::ST_IDLE;
      default: state_d = spi_flag_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= spi_flag_pkg::ST_IDLE;
      sck_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sck_prev_q <= sck_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
      sck_gen_q <= 1'b0;
    end else if (gen_on && !abort) begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
      sck_gen_q <= tick ? !sck_gen_q : sck_gen_q;
    end else begin
      div_q <= 16'h0000;
      sck_gen_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      cnt_q <= 3'h0;
    end else if (load) begin
      sh_q <= tx_byte;
      cnt_q <= 3'h0;
    end else if (state_q == spi_flag_pkg::ST_SHIFT) begin
      if (rise) begin
        rx_q <= {rx_q[6:0], sdi_s};
      end
      if (fall) begin
        sh_q <= {sh_q[6:0], 1'b0};
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  assign busy = (state_q != spi_flag_pkg::ST_IDLE); // [R9]
  assign done = (state_q == spi_flag_pkg::ST_END);
  assign rx_byte = rx_q;
  assign sck_out = sck_gen_q;
  assign sdo = sh_q[7];
endmodule

// ===== core/spi_status_flag_logic.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "spi_flag_consts.svh"
module spi_status_flag_logic #(
  parameter int HALF_CYC = `SCK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic irq_ack,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in
);
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    return a[11:2] == idx;
  endfunction

  // Pin synchronisers: sck, select, mosi, miso
  logic [3:0] pin_raw;
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  assign pin_raw = {sck_in, ss_n_in, mosi_in, miso_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[gi] <= (gi == 2) ? 1'b1 : 1'b0;
          sync_q[gi] <= (gi == 2) ? 1'b1 : 1'b0;
        end else begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  wire sck_s = sync_q[3];
  wire ss_n_s = sync_q[2];
  wire mosi_s = sync_q[1];
  wire miso_s = sync_q[0];

  // Registers
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] mask_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic cpl_q;
  logic coll_q;
  logic fault_q;
  logic ovf_q;
  logic full_q;
  logic [31:0] rdata_q;

  // Shifter side
  logic busy;
  logic done;
  logic [7:0] rx_byte;
  logic sck_gen;
  logic sdo;

  // Bus decode
  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire sel_status = hit(paddr, `IDX_STATUS);
  wire sel_data = hit(paddr, `IDX_DATA);
  wire sel_ctrl = hit(paddr, `IDX_CTRL);
  wire sel_mask = hit(paddr, `IDX_MASK);
  wire mapped = sel_status || sel_data || sel_ctrl || sel_mask;
  wire wr_status = wr && sel_status;
  wire wr_data = wr && sel_data;
  wire wr_ctrl = wr && sel_ctrl;
  wire wr_mask = wr && sel_mask;
  wire rd_data = rd && sel_data;

  // Control bits
  wire en = ctrl_q[`CTL_EN];
  wire ctrlr = ctrl_q[`CTL_CTRLR];
  wire sel_dis = ctrl_q[`CTL_SELDIS];

  // Status events
  wire start = wr_data && !busy && en && ctrlr; // [R13]
  wire coll_set = wr_data && busy; // [R1]
  wire coll_clr = (wr_status && !pwdata[`BIT_COLL]) || (wr_data && !busy); // [R2]
  wire fault_set = en && ctrlr && !sel_dis && !ss_n_s; // [R3]
  wire fault_clr = wr_status && !pwdata[`BIT_FAULT]; // [R4]
  wire ovf_set = done && full_q; // [R6]
  wire ovf_clr = (wr_status && !pwdata[`BIT_OVF]) || rd_data; // [R7]
  wire full_set = done; // [R8]
  wire full_clr = (wr_status && !pwdata[`BIT_FULL]) || rd_data; // [R8]
  wire cpl_set = done;
  wire cpl_clr = (wr_status && !pwdata[`BIT_CPL]) || irq_ack; // [R12]

  wire [7:0] status_v = {cpl_q, coll_q, fault_q, ovf_q, full_q, busy, 2'h0}; // [R9]
  wire sdi = ctrlr ? miso_s : mosi_s;
  // Starting byte bypasses the data register, which updates on the same edge
  wire [7:0] tx_next = start ? pwdata[7:0] : tx_q; // [R10]

  wire [7:0] rd_mux = sel_status ? status_v :
                      sel_data ? rx_q : // [R10]
                      sel_ctrl ? ctrl_q :
                      sel_mask ? mask_q : 8'h00;

  spi_shifter #(
    .HALF_CYC(HALF_CYC)
  ) u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .enable(en),
    .controller(ctrlr),
    .start(start),
    .tx_byte(tx_next),
    .sck_s(sck_s),
    .sel_n_s(ss_n_s),
    .sdi_s(sdi),
    .busy(busy),
    .done(done),
    .rx_byte(rx_byte),
    .sck_out(sck_gen),
    .sdo(sdo)
  );

  // Fault wins over a same-cycle software write
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = pwdata[7:0] & `CTL_WMASK;
    end
    if (fault_set) begin
      ctrl_d[`CTL_EN] = 1'b0; // [R5]
      ctrl_d[`CTL_CTRLR] = 1'b0; // [R5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `MASK_RST;
    end else if (wr_mask) begin
      mask_q <= pwdata[7:0];
    end
  end

  // Colliding write is dropped so the byte on the wire stays intact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= `DATA_RST;
    end else if (wr_data && !busy) begin
      tx_q <= pwdata[7:0]; // [R10]
    end
  end

  // Newest byte kept on overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= `DATA_RST;
    end else if (done) begin
      rx_q <= rx_byte; // [R10]
    end
  end

  // Sticky flags, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coll_q <= 1'b0; // [R11]
    end else begin
      coll_q <= coll_set || (coll_q && !coll_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0; // [R11]
    end else begin
      fault_q <= fault_set || (fault_q && !fault_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0; // [R11]
    end else begin
      ovf_q <= ovf_set || (ovf_q && !ovf_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q <= 1'b0; // [R11]
    end else begin
      full_q <= full_set || (full_q && !full_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpl_q <= 1'b0;
    end else begin
      cpl_q <= cpl_set || (cpl_q && !cpl_clr);
    end
  end

  // Read data latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup) begin
      rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign irq = |(status_v & mask_q);

  // Pins
  assign sck_out = sck_gen;
  assign sck_oe = en && ctrlr;
  assign mosi_out = sdo;
  assign mosi_oe = en && ctrlr;
  assign miso_out = sdo;
  assign miso_oe = en && !ctrlr && !ss_n_s;
endmodule

// ===== testbench/spi_flag_chk.sv
`timescale 1ns/10ps
module spi_flag_chk #(
  parameter int HALF_CYC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_n_in
);
  logic sck_prev_q;
  int sck_cnt_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since the serial clock last moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_q <= 1'h0;
      sck_cnt_q <= 0;
    end else begin
      sck_prev_q <= sck_out;
      sck_cnt_q <= (sck_out != sck_prev_q) ? 0 : sck_cnt_q + 1;
    end
  end
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_unmap; psel && penable && paddr[11:2] < 10'h0bd |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped accepted");
  property p_map;
    psel && penable && paddr[11:2] inside {[10'h0bd:10'h0c0]} |-> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_oe; !sck_oe |=> !sck_out; endproperty
  a_oe: assert property (p_oe) else $error("clock moves while released");
  property p_excl; miso_oe |-> !mosi_oe; endproperty
  a_excl: assert property (p_excl) else $error("both data lines driven");
  property p_fault; sck_oe && $fell(ss_n_in) |-> ##[1:6] !sck_oe; endproperty
  a_fault: assert property (p_fault) else $error("fault kept controller");
  property p_half; $fell(sck_out) |-> sck_cnt_q == HALF_CYC - 1; endproperty
  a_half: assert property (p_half) else $error("clock high time wrong");
endmodule

// ===== testbench/spi_peer_model.sv
`timescale 1ns/10ps
module spi_peer_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  output logic sck_drv,
  output logic mosi_drv,
  output logic miso_drv,
  output logic ss_n
);
  logic [7:0] tx_q = 8'h00;
  logic [7:0] rx_q = 8'h00;
  logic lead = 1'h0;
  // Released line shows the inverse so stale data never matches
  assign mosi_drv = lead ? tx_q[7] : ~tx_q[7];
  assign miso_drv = lead ? ~tx_q[7] : tx_q[7];
  initial begin
    sck_drv = 1'h0;
    ss_n = 1'h1;
  end
  always @(posedge sck) rx_q <= {rx_q[6:0], lead ? miso : mosi};
  always @(negedge sck) tx_q <= {tx_q[6:0], ~tx_q[0]};
  task automatic load(input logic [7:0] v, input logic l);
    tx_q <= v;
    lead <= l;
  endtask
  task automatic sel(input logic v);
    ss_n <= v;
  endtask
  // Clock only inside the frame, odd offset keeps it off the core phase
  task automatic frame();
    #137 ss_n = 1'h0;
    repeat (8) begin
      #400 sck_drv = 1'h1;
      #400 sck_drv = 1'h0;
    end
    #400 ss_n = 1'h1;
  endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam logic [11:0] ST = 12'h2f4;
  localparam logic [11:0] DT = 12'h2f8;
  localparam logic [11:0] CT = 12'h2fc;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic irq_ack = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic p_sck, p_mosi, p_miso, ss_n, err;
  logic [7:0] r, a, b, ms = 8'h00;
  logic [7:0] rxq[$];
  int fail_count = 0, cmp_count = 0, cyc = 0;
  wire sck_w = sck_oe ? sck_out : p_sck;
  wire mosi_w = mosi_oe ? mosi_out : p_mosi;
  wire miso_w = miso_oe ? miso_out : p_miso;
  spi_status_flag_logic #(.HALF_CYC(4)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .irq_ack, .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out, .mosi_oe,
    .miso_in(miso_w), .miso_out, .miso_oe, .ss_n_in(ss_n)
  );
  spi_peer_model peer_u (
    .sck(sck_w), .mosi(mosi_w), .miso(miso_w), .sck_drv(p_sck), .mosi_drv(p_mosi),
    .miso_drv(p_miso), .ss_n
  );
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] ad, input logic w, input logic [7:0] d);
    psel <= 1'h1;
    paddr <= ad;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    r = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [7:0] exp);
    apb(ad, 1'h0, 8'h00);
    chk(r, exp);
  endtask
  // Poll until idle, then the model closes the byte
  task automatic wait_end();
    do apb(ST, 1'h0, 8'h00); while (r[2] === 1'h1);
    ms = {1'h1, ms[6:5], ms[4] | ms[3], 1'h1, 3'h0};
  endtask
  initial begin
    a = 8'($urandom(18));
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(ST, ms);
    rd(CT, 8'h00);
    rd(12'h010, 8'h00);
    chk({7'h0, err}, 8'h01);
    $display("test reset done");
    apb(CT, 1'h1, 8'h03);
    for (int i = 0; i < 2; i++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      rxq.push_back(b);
      peer_u.load(b, 1'h0);
      apb(DT, 1'h1, a);
      ms[6] = 1'h0;
      ms[2] = 1'h1;
      rd(ST, ms);
      apb(DT, 1'h1, ~a);
      ms[6] = 1'h1;
      rd(ST, ms);
      if (i == 1) begin
        apb(ST, 1'h1, 8'hbf);
        ms[6] = 1'h0;
      end
      wait_end();
      chk(peer_u.rx_q, a);
      rd(ST, ms);
    end
    rd(DT, rxq.pop_back());
    ms[4:3] = 2'h0;
    rd(ST, ms);
    $display("test transfers done");
    chk({7'h0, irq}, 8'h00);
    apb(12'h300, 1'h1, 8'h80);
    rd(12'h300, 8'h80);
    chk({7'h0, irq}, 8'h01);
    irq_ack <= 1'h1;
    @(posedge pclk);
    irq_ack <= 1'h0;
    @(posedge pclk);
    ms[7] = 1'h0;
    chk({7'h0, irq}, 8'h00);
    rd(ST, ms);
    $display("test interrupt done");
    apb(CT, 1'h1, 8'h03);
    peer_u.sel(1'h0);
    repeat (6) @(posedge pclk);
    ms[5] = 1'h1;
    rd(ST, ms);
    rd(CT, 8'h00);
    peer_u.sel(1'h1);
    repeat (4) @(posedge pclk);
    rd(ST, ms);
    apb(ST, 1'h1, 8'hdf);
    ms[5] = 1'h0;
    rd(ST, ms);
    peer_u.sel(1'h0);
    apb(CT, 1'h1, 8'h07);
    repeat (4) @(posedge pclk);
    rd(ST, ms);
    rd(CT, 8'h07);
    peer_u.sel(1'h1);
    repeat (2) @(posedge pclk);
    $display("test fault done");
    apb(CT, 1'h1, 8'h01);
    b = 8'($urandom);
    apb(DT, 1'h1, a);
    peer_u.load(b, 1'h1);
    peer_u.frame();
    repeat (4) @(posedge pclk);
    wait_end();
    chk(peer_u.rx_q, a);
    rd(ST, ms);
    apb(ST, 1'h1, 8'hf7);
    ms[3] = 1'h0;
    rd(ST, ms);
    rd(DT, b);
    $display("test peripheral done");
    report_and_stop();
  end
endmodule
bind spi_status_flag_logic spi_flag_chk #(.HALF_CYC(HALF_CYC)) chk_u (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .sck_out, .sck_oe, .mosi_oe,
  .miso_oe, .ss_n_in
);
